/* rtl/sptxab_pkg.sv */
package sptxab_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NUM_ARRAYS = 8;
    localparam int NUM_WORDS  = 12;
    localparam int WORD_W     = 16;
    localparam int FRAME_W    = 8;
    localparam int IDX_W      = 16;

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite
    localparam int          IDX_LSB        = 2;
    localparam int          IDX_MSB        = 17;
    localparam int          HADDR_HI_LSB   = 18;
    localparam logic [13:0] HADDR_HI_ZERO  = 14'h0000;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;
    localparam logic        HRESP_OKAY     = 1'h0;
    localparam logic [15:0] RDATA_PAD      = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // register indexes (byte address is four times the index)
    localparam logic [15:0] IDX_AUX_STATUS            = 16'hF69E;
    localparam logic [15:0] IDX_AUX_BITS_SOURCE_SELECT = 16'hF69F;
    localparam logic [15:0] IDX_TX_LEFT_CHANNEL_STATUS  = 16'hF6A0;
    localparam logic [15:0] IDX_TX_RIGHT_CHANNEL_STATUS = 16'hF6B0;
    localparam logic [15:0] IDX_TX_LEFT_USER_BITS       = 16'hF6C0;
    localparam logic [15:0] IDX_TX_RIGHT_USER_BITS      = 16'hF6D0;
    localparam logic [15:0] IDX_TX_LEFT_VALIDITY        = 16'hF6E0;
    localparam logic [15:0] IDX_TX_RIGHT_VALIDITY       = 16'hF6F0;
    localparam logic [15:0] IDX_TX_LEFT_PARITY          = 16'hF700;
    localparam logic [15:0] IDX_TX_RIGHT_PARITY         = 16'hF710;
    localparam logic [15:0] IDX_ARR_STRIDE              = 16'h0010;
    localparam logic [11:0] ARR_GROUP_FIRST = 12'hF6A;
    localparam logic [11:0] ARR_GROUP_LAST  = 12'hF71;
    localparam logic [3:0]  WORD_LAST       = 4'hB;

    ////////////////////////////////////////////////////////////////////////////
    // fields and reset values
    localparam int          SRC_SEL_BIT    = 0;
    localparam logic        SRC_BANK       = 1'h0;
    localparam logic        SRC_RX         = 1'h1;
    localparam logic [15:0] RESET_WORD     = 16'h0000;
    localparam logic [6:0]  STAT_RSVD      = 7'h00;
    localparam logic [7:0]  FIRST_FRAME    = 8'h00;
    localparam logic [7:0]  BLOCK_LAST_FRAME = 8'hBF;

    // position of each category in the bank and on auxBits
    typedef enum logic [2:0]
    {
        AUX_CS_L = 3'h0,
        AUX_CS_R = 3'h1,
        AUX_UD_L = 3'h2,
        AUX_UD_R = 3'h3,
        AUX_VB_L = 3'h4,
        AUX_VB_R = 3'h5,
        AUX_PB_L = 3'h6,
        AUX_PB_R = 3'h7
    } sptxab_arr_e;

    typedef logic [NUM_WORDS-1:0][WORD_W-1:0] sptxab_words_t;

endpackage

/* rtl/sptxab_bit_pick.sv */
`timescale 1ns/10ps
`default_nettype none

module sptxab_bit_pick
(
    input  wire logic [sptxab_pkg::NUM_WORDS-1:0][sptxab_pkg::WORD_W-1:0] words,
    input  wire logic [sptxab_pkg::FRAME_W-1:0]                           frameIdx,
    output logic                                                          bitOut
);

    logic [3:0] wordSel;
    logic [3:0] bitSel;

    assign wordSel = frameIdx[7:4];
    assign bitSel  = frameIdx[3:0];

    // word k carries frames 16k..16k+15, bit 0 the lowest frame
    always_comb
    begin
        bitOut = 1'h0;
        if (wordSel <= sptxab_pkg::WORD_LAST)
        begin
            bitOut = words[wordSel][bitSel]; // [RQ14]
        end
    end

endmodule

`default_nettype wire

/* rtl/sptxab_bank.sv */
// Overview of operation
// [RQ1] Source select 0: every non-audio bit comes from the register bank.
// [RQ2] Source select 1: non-audio bits are copied from the receiver's decoded bits.
// [RQ3] Source select register resets to zero; its upper fifteen bits are reserved.
// [RQ4] Bank mode lets software set status, parity, user and validity independently.
// [RQ5] Left channel status: twelve 16-bit read-write registers, reset zero.
// [RQ6] Right channel status: twelve 16-bit read-write registers, reset zero.
// [RQ7] Left user data: twelve 16-bit read-write registers, reset zero.
// [RQ8] Right user data: twelve 16-bit read-write registers, reset zero.
// [RQ9] Left validity: twelve 16-bit read-write registers, reset zero.
// [RQ10] Right validity: twelve 16-bit read-write registers, reset zero.
// [RQ11] Left parity: twelve 16-bit read-write registers, reset zero.
// [RQ12] Software clears source select before programmed bits appear on the stream.
// [RQ13] Right parity: twelve 16-bit read-write registers, reset zero.
// [RQ14] Register k supplies frame bits 16k..16k+15, bit 0 the lowest frame.
// [RQ15] Source and bit changes take effect only at a 192-frame block boundary.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module sptxab_bank
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        frameStrobe,
    input  wire logic [7:0]  frameIndex,
    input  wire logic [7:0]  rxAuxBits,
    output logic [7:0]       auxBits,
    output logic             auxValid,
    output logic             auxSourceActive
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed
    {
        logic [sptxab_pkg::NUM_ARRAYS-1:0][sptxab_pkg::NUM_WORDS-1:0]
              [sptxab_pkg::WORD_W-1:0]            bank;
        logic [sptxab_pkg::NUM_ARRAYS-1:0][sptxab_pkg::NUM_WORDS-1:0]
              [sptxab_pkg::WORD_W-1:0]            active;
        logic [sptxab_pkg::WORD_W-1:0]            srcSel;
        logic                                     activeSrc;
        logic [sptxab_pkg::FRAME_W-1:0]           lastFrame;
        logic                                     wrPend;
        logic [sptxab_pkg::IDX_W-1:0]             wrIdx;
        logic [31:0]                              rdata;
        logic [7:0]                               auxBits;
        logic                                     auxValid;
    } sptxab_state_s;

    sptxab_state_s st;
    sptxab_state_s next_st;

    logic                                  addrPhase;
    logic                                  addrMapped;
    logic [sptxab_pkg::IDX_W-1:0]          addrIdx;
    logic                                  boundary;
    logic [sptxab_pkg::NUM_ARRAYS-1:0]     pickActive;
    logic [sptxab_pkg::NUM_ARRAYS-1:0]     pickBank;
    logic [11:0]                           wrGroup;
    logic [11:0]                           rdGroup;

    ////////////////////////////////////////////////////////////////////////////
    // address helpers

    function automatic logic arr_hit(input logic [15:0] idx);
        return (idx[15:4] >= sptxab_pkg::ARR_GROUP_FIRST)
            && (idx[15:4] <= sptxab_pkg::ARR_GROUP_LAST)
            && (idx[3:0] <= sptxab_pkg::WORD_LAST);
    endfunction

    assign addrIdx    = haddr[sptxab_pkg::IDX_MSB:sptxab_pkg::IDX_LSB];
    // upper address bits must be zero, so the map does not alias
    assign addrMapped = (haddr[31:sptxab_pkg::HADDR_HI_LSB] == sptxab_pkg::HADDR_HI_ZERO);
    assign addrPhase  = hsel && hready && (htrans == sptxab_pkg::HTRANS_NONSEQ) && addrMapped;
    assign boundary   = frameStrobe && (frameIndex == sptxab_pkg::FIRST_FRAME);
    assign wrGroup    = st.wrIdx[15:4] - sptxab_pkg::ARR_GROUP_FIRST;
    assign rdGroup    = addrIdx[15:4] - sptxab_pkg::ARR_GROUP_FIRST;

    ////////////////////////////////////////////////////////////////////////////
    // per-frame bit pickers, one per category and per copy

    genvar gi;
    generate
        for (gi = 0; gi < sptxab_pkg::NUM_ARRAYS; gi++)
        begin : g_pick
            sptxab_bit_pick u_pick_active
            (
                .words    (st.active[gi]),
                .frameIdx (frameIndex),
                .bitOut   (pickActive[gi])
            );
            sptxab_bit_pick u_pick_bank
            (
                .words    (st.bank[gi]),
                .frameIdx (frameIndex),
                .bitOut   (pickBank[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_st = st;

        // data phase of a write: each category stored on its own
        if (st.wrPend)
        begin
            if (st.wrIdx == sptxab_pkg::IDX_AUX_BITS_SOURCE_SELECT)
            begin
                next_st.srcSel = hwdata[15:0]; // [RQ3]
            end
            else if (arr_hit(st.wrIdx))
            begin
                next_st.bank[wrGroup[2:0]][st.wrIdx[3:0]] = hwdata[15:0]; // [RQ4]
            end
        end

        next_st.wrPend = addrPhase && hwrite && (hsize == sptxab_pkg::HSIZE_WORD);
        next_st.wrIdx  = addrIdx;

        // read sees a write still in its data phase
        if (addrPhase && !hwrite)
        begin
            next_st.rdata = 32'h0000_0000;
            if (addrIdx == sptxab_pkg::IDX_AUX_BITS_SOURCE_SELECT)
            begin
                next_st.rdata = {sptxab_pkg::RDATA_PAD, next_st.srcSel}; // [RQ3]
            end
            else if (addrIdx == sptxab_pkg::IDX_AUX_STATUS)
            begin
                next_st.rdata = {sptxab_pkg::RDATA_PAD, st.lastFrame,
                                 sptxab_pkg::STAT_RSVD, st.activeSrc};
            end
            else if (arr_hit(addrIdx))
            begin
                next_st.rdata = {sptxab_pkg::RDATA_PAD,
                                 next_st.bank[rdGroup[2:0]][addrIdx[3:0]]};
            end
        end

        // take over the programmed set only when a block starts
        if (boundary)
        begin
            next_st.active    = st.bank; // [RQ15]
            next_st.activeSrc = st.srcSel[sptxab_pkg::SRC_SEL_BIT]; // [RQ15]
        end

        next_st.auxValid = frameStrobe;
        if (frameStrobe)
        begin
            next_st.lastFrame = frameIndex;
            if (boundary)
            begin
                if (st.srcSel[sptxab_pkg::SRC_SEL_BIT] == sptxab_pkg::SRC_RX)
                begin
                    next_st.auxBits = rxAuxBits; // [RQ2]
                end
                else
                begin
                    next_st.auxBits = pickBank; // [RQ1]
                end
            end
            else if (st.activeSrc == sptxab_pkg::SRC_RX)
            begin
                next_st.auxBits = rxAuxBits; // [RQ2]
            end
            else
            begin
                // bank mode is what makes programmed bits reach the stream
                next_st.auxBits = pickActive; // [RQ1] [RQ12]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers: every register and array clears to zero

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st <= '0; // [RQ3] [RQ5] [RQ6] [RQ7] [RQ8] [RQ9] [RQ10] [RQ11] [RQ13]
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // zero wait state, never an error
    assign hreadyout       = 1'h1;
    assign hresp           = sptxab_pkg::HRESP_OKAY;
    assign hrdata          = st.rdata;
    assign auxBits         = st.auxBits;
    assign auxValid        = st.auxValid;
    assign auxSourceActive = st.activeSrc;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!rst_n);

    sequence write_addr(logic [15:0] idx);
        hsel && hready && (htrans == sptxab_pkg::HTRANS_NONSEQ) && hwrite
            && (hsize == sptxab_pkg::HSIZE_WORD) && (haddr == {14'h0000, idx, 2'h0});
    endsequence

    sequence read_addr(logic [15:0] idx);
        hsel && hready && (htrans == sptxab_pkg::HTRANS_NONSEQ) && !hwrite
            && (haddr == {14'h0000, idx, 2'h0});
    endsequence

    sequence mid_block_frame;
        frameStrobe && !boundary && (frameIndex <= sptxab_pkg::BLOCK_LAST_FRAME);
    endsequence

    // block start taken while the programmed source select names src
    sequence block_start(logic src);
        boundary && (st.srcSel[sptxab_pkg::SRC_SEL_BIT] == src);
    endsequence

    reset_clear_a: assert property ( // [RQ3]
        !$past(rst_n) |-> (st.srcSel == sptxab_pkg::RESET_WORD) && !st.activeSrc
            && (st.bank == '0) && !auxValid)
        else $error("state not zero after reset");

    generate
        for (gi = 0; gi < sptxab_pkg::NUM_ARRAYS; gi++)
        begin : g_wr_chk
            localparam logic [15:0] BASE_IDX =
                sptxab_pkg::IDX_TX_LEFT_CHANNEL_STATUS + 16'(gi) * sptxab_pkg::IDX_ARR_STRIDE;
            array_write_a: assert property ( // [RQ5] [RQ6] [RQ7] [RQ8] [RQ9] [RQ10] [RQ11] [RQ13]
                write_addr(BASE_IDX + 16'h000B) ##1 1'b1
                    |=> st.bank[gi][sptxab_pkg::WORD_LAST] == $past(hwdata[15:0]))
                else $error("bit array word not written");
        end
    endgenerate

    independent_cat_a: assert property ( // [RQ4]
        write_addr(sptxab_pkg::IDX_TX_LEFT_CHANNEL_STATUS) ##1 1'b1
            |=> st.bank[sptxab_pkg::AUX_CS_R] == $past(st.bank[sptxab_pkg::AUX_CS_R])
                && st.bank[sptxab_pkg::AUX_PB_L] == $past(st.bank[sptxab_pkg::AUX_PB_L]))
        else $error("write disturbed another category");

    src_read_a: assert property ( // [RQ3]
        read_addr(sptxab_pkg::IDX_AUX_BITS_SOURCE_SELECT) ##1 !st.wrPend
            |-> hrdata == {sptxab_pkg::RDATA_PAD, st.srcSel})
        else $error("source select read wrong");

    mid_hold_a: assert property ( // [RQ15]
        !boundary |=> $stable(st.activeSrc) && $stable(st.active))
        else $error("active set changed inside a block");

    boundary_load_a: assert property ( // [RQ15]
        boundary |=> (st.activeSrc == $past(st.srcSel[0])) && (st.active == $past(st.bank))
            && auxValid)
        else $error("block start did not load active set");

    rx_copy_a: assert property ( // [RQ2]
        mid_block_frame and (st.activeSrc == sptxab_pkg::SRC_RX)
            |=> auxValid && (auxBits == $past(rxAuxBits)))
        else $error("receiver bits not copied");

    bank_pick_a: assert property ( // [RQ1] [RQ14]
        mid_block_frame and (st.activeSrc == sptxab_pkg::SRC_BANK)
            |=> auxBits[sptxab_pkg::AUX_CS_L]
                == $past(st.active[sptxab_pkg::AUX_CS_L][frameIndex[7:4]][frameIndex[3:0]]))
        else $error("bank bit not selected");

    last_frame_a: assert property ( // [RQ14]
        frameStrobe && (frameIndex == sptxab_pkg::BLOCK_LAST_FRAME)
            && (st.activeSrc == sptxab_pkg::SRC_BANK)
            |=> auxValid
                && (auxBits[sptxab_pkg::AUX_PB_R]
                    == $past(st.active[sptxab_pkg::AUX_PB_R][sptxab_pkg::WORD_LAST][15])))
        else $error("last frame bit misplaced");

    src_write_a: assert property ( // [RQ3]
        write_addr(sptxab_pkg::IDX_AUX_BITS_SOURCE_SELECT) ##1 1'b1
            |=> st.srcSel == $past(hwdata[15:0]))
        else $error("source select not written");

    // word twelve of the last array must not alias a real register
    unmapped_read_a: assert property ( // [RQ13]
        hsel && hready && (htrans == sptxab_pkg::HTRANS_NONSEQ) && !hwrite && addrMapped
            && !arr_hit(addrIdx) && (addrIdx != sptxab_pkg::IDX_AUX_BITS_SOURCE_SELECT)
            && (addrIdx != sptxab_pkg::IDX_AUX_STATUS)
            |=> hrdata == '0)
        else $error("unmapped read not zero");

    status_read_a: assert property ( // [RQ15]
        read_addr(sptxab_pkg::IDX_AUX_STATUS)
            |=> hrdata == {sptxab_pkg::RDATA_PAD, $past(st.lastFrame),
                           sptxab_pkg::STAT_RSVD, $past(st.activeSrc)})
        else $error("status read wrong");

    rdata_hold_a: assert property (
        !(hsel && hready && (htrans == sptxab_pkg::HTRANS_NONSEQ) && !hwrite)
            |=> $stable(hrdata))
        else $error("read data moved without a read");

    valid_pulse_a: assert property (
        frameStrobe |=> auxValid)
        else $error("no valid after strobe");

    valid_single_a: assert property (
        !frameStrobe |=> !auxValid)
        else $error("valid without strobe");

    // encoder may sample the bits late, so they must stand between strobes
    bits_hold_a: assert property (
        !frameStrobe |=> $stable(auxBits))
        else $error("aux bits moved between strobes");

    out_range_a: assert property ( // [RQ14]
        frameStrobe && (frameIndex > sptxab_pkg::BLOCK_LAST_FRAME)
            && (st.activeSrc == sptxab_pkg::SRC_BANK)
            |=> auxBits == '0)
        else $error("frame past block end not zero");

    start_rx_copy_a: assert property ( // [RQ2]
        block_start(sptxab_pkg::SRC_RX) |=> auxBits == $past(rxAuxBits))
        else $error("block start lost receiver bits");

    start_bank_pick_a: assert property ( // [RQ1] [RQ15]
        block_start(sptxab_pkg::SRC_BANK)
            |=> auxBits[sptxab_pkg::AUX_PB_R]
                == $past(st.bank[sptxab_pkg::AUX_PB_R][frameIndex[7:4]][frameIndex[3:0]]))
        else $error("block start lost programmed bit");

endmodule

`default_nettype wire

/* testbench/sptxab_frame_src.sv */
`timescale 1ns/10ps
`default_nettype none

module sptxab_frame_src
(
    input  wire logic       clk,
    input  wire logic [7:0] auxBits,
    input  wire logic       auxValid,
    output logic            frameStrobe,
    output logic [7:0]      frameIndex,
    output logic [7:0]      rxAuxBits
);

    initial
    begin
        frameStrobe = 1'h0;
        frameIndex  = 8'hFF;
        rxAuxBits   = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one frame per cycle, entered just off an edge, so calls may run back to back
    task automatic send(input logic [7:0] idx, input logic [7:0] rx,
                        output logic vld, output logic [7:0] bits);
        frameStrobe <= 1'h1;
        frameIndex  <= idx;
        rxAuxBits   <= rx;
        @(posedge clk);
        frameStrobe <= 1'h0;
        // stale lines do not hold: show the inverse so nothing leans on them
        frameIndex  <= ~idx;
        rxAuxBits   <= ~rx;
        #1;
        vld  = auxValid;
        bits = auxBits;
    endtask

endmodule

`default_nettype wire

/* testbench/spdif_tx_aux_bits_bank_test.sv */
`timescale 1ns/10ps
`default_nettype none

module spdif_tx_aux_bits_bank_test;

    localparam int      LIMIT = 20000;
    localparam logic [15:0] SRC = sptxab_pkg::IDX_AUX_BITS_SOURCE_SELECT;
    logic               clk;
    logic               rst_n;
    logic               hsel;
    logic               hwrite;
    logic               hready;
    logic               hreadyout;
    logic               hresp;
    logic [31:0]        haddr;
    logic [31:0]        hwdata;
    logic [31:0]        hrdata;
    logic [31:0]        rd;
    logic [1:0]         htrans;
    logic [2:0]         hsize;
    logic               frameStrobe;
    logic               auxValid;
    logic               auxSourceActive;
    logic [7:0]         frameIndex;
    logic [7:0]         rxAuxBits;
    logic [7:0]         auxBits;
    logic [15:0]        prog [8][12];
    logic [15:0]        act [8][12];
    logic               srcProg;
    logic               srcAct;
    int                 n_mismatch;
    int                 total_checks;
    int                 cycles;

    assign hready = hreadyout;

    sptxab_bank i_sptxab_bank
    (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .frameStrobe(frameStrobe), .frameIndex(frameIndex), .rxAuxBits(rxAuxBits),
        .auxBits(auxBits), .auxValid(auxValid), .auxSourceActive(auxSourceActive)
    );

    sptxab_frame_src i_sptxab_frame_src
    (
        .clk(clk), .auxBits(auxBits), .auxValid(auxValid), .frameStrobe(frameStrobe),
        .frameIndex(frameIndex), .rxAuxBits(rxAuxBits)
    );

    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        hsel   <= 1'h1;
        haddr  <= {14'h0000, idx, 2'h0};
        htrans <= sptxab_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= sptxab_pkg::HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask

    function automatic logic [15:0] base(input int a, input int w);
        return sptxab_pkg::IDX_TX_LEFT_CHANNEL_STATUS + 16'(a * 16 + w);
    endfunction

    task automatic wr(input logic [15:0] idx, input logic [15:0] v);
        ahb(1'h1, idx, {16'hFFFF, v});
        if (idx == SRC)
            srcProg = v[0];
        else
            prog[(idx - base(0, 0)) >> 4][idx[3:0]] = v;
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [15:0] exp, input string what);
        ahb(1'h0, idx, 32'h00000000);
        chk(rd, {16'h0000, exp}, what);
        chk({31'h0, hresp}, {31'h0, sptxab_pkg::HRESP_OKAY}, "response");
    endtask

    function automatic logic [7:0] expBits(input logic [7:0] f, input logic [7:0] rx);
        logic [7:0] b;
        b = 8'h00;
        if (srcAct)
            return rx;
        if (f <= sptxab_pkg::BLOCK_LAST_FRAME)
            for (int a = 0; a < 8; a++)
                b[a] = act[a][f / 16][f % 16];
        return b;
    endfunction

    // the model swaps in programmed values only at a block start
    task automatic frame(input logic [7:0] f, input logic [7:0] rx);
        logic       v;
        logic [7:0] b;
        if (f == 8'h00)
        begin
            act    = prog;
            srcAct = srcProg;
        end
        i_sptxab_frame_src.send(f, rx, v, b);
        chk({31'h0, v}, 32'h1, "aux valid");
        chk({24'h0, b}, {24'h0, expBits(f, rx)}, "aux bits");
        chk({31'h0, auxSourceActive}, {31'h0, srcAct}, "active source");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdchk(SRC, 16'h0000, "source reset");
        for (int a = 0; a < 8; a++)
        begin
            rdchk(base(a, 0), 16'h0000, "array reset");
            rdchk(base(a, 11), 16'h0000, "array reset");
        end
    endtask

    task automatic t_regs();
        for (int a = 0; a < 8; a++)
            for (int w = 0; w < 12; w++)
                wr(base(a, w), 16'((a * 12 + w + 1) * 16'h1357));
        for (int a = 0; a < 8; a++)
            for (int w = 0; w < 12; w++)
                rdchk(base(a, w), prog[a][w], "array rw");
        wr(SRC, 16'hFFFE);
        rdchk(SRC, 16'hFFFE, "reserved bits rw");
        ahb(1'h1, 16'hF71C, 32'h0000FFFF);
        rdchk(16'hF71C, 16'h0000, "unmapped read");
    endtask

    task automatic t_bank();
        wr(SRC, 16'h0000);
        for (int f = 0; f < 192; f++)
            frame(8'(f), 8'(~f));
        frame(8'hC8, 8'hFF);
        rdchk(sptxab_pkg::IDX_AUX_STATUS, 16'hC800, "status");
    endtask

    task automatic t_bound();
        frame(8'h00, 8'h11);
        frame(8'h01, 8'h22);
        wr(base(0, 0), ~prog[0][0]);
        wr(base(7, 11), 16'hFFFF);
        frame(8'h02, 8'h33);
        frame(8'hBF, 8'h44);
        frame(8'h00, 8'h55);
        frame(8'hBF, 8'h66);
        wr(SRC, 16'h0001);
        frame(8'h10, 8'h77);
    endtask

    task automatic t_rx();
        frame(8'h00, 8'h80);
        for (int i = 0; i < 8; i++)
            frame(8'(i + 1), 8'h01 << i);
        frame(8'hC8, 8'hA5);
        wr(SRC, 16'h0000);
        frame(8'h05, 8'h5A);
        frame(8'h00, 8'h5A);
    endtask

    // reset in mid-run, with source select, arrays, read data and aux outputs away from zero
    task automatic t_rst2();
        wr(SRC, 16'h0001);
        frame(8'h00, 8'hC3);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        #1;
        foreach (prog[a, w])
            prog[a][w] = 16'h0000;
        srcProg = 1'h0;
        srcAct  = 1'h0;
        chk(hrdata, 32'h00000000, "read data reset");
        chk({23'h0, auxValid, auxBits}, 32'h0, "aux reset");
        chk({31'h0, auxSourceActive}, 32'h0, "source reset");
        t_reset();
        frame(8'h00, 8'h3C);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n        = 1'h0;
        hsel         = 1'h0;
        haddr        = 32'h00000000;
        htrans       = 2'h0;
        hwrite       = 1'h0;
        hsize        = sptxab_pkg::HSIZE_WORD;
        hwdata       = 32'h00000000;
        n_mismatch   = 0;
        total_checks = 0;
        cycles       = 0;
        srcProg      = 1'h0;
        srcAct       = 1'h0;
        foreach (prog[a, w])
        begin
            prog[a][w] = 16'h0000;
            act[a][w]  = 16'h0000;
        end
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        t_reset();
        t_regs();
        t_bank();
        t_bound();
        t_rx();
        t_rst2();
        complete_run();
    end

endmodule

`default_nettype wire
